// *** srs_pkg.sv ***
// Overview of operation
// - An 8-bit free-running rate timer, period set by baud_divisor, serves both modes.
// - high_rate_select picks the multiplier when asynchronous and is ignored when synchronous.
// - Bit rate is clock over 64, 16 or 4 times (divisor plus one).
// - Any write to baud_divisor clears the rate timer at once.
// - One clock line, one two-way data line; never transmit and receive together.
// - The port works either as clock master or as slave on an external clock.
// - Synchronous characters carry data bits only, no start or stop bit.
// - As master the port drives the clock pin and enables its driver automatically.
// - A data bit changes on the clock leading edge, valid until the next one.
// - Exactly one clock cycle per data bit, and no extra cycles.
// - Master transmit drives the data pin and enables both pin drivers automatically.
// - Writing the holding register starts a send; it waits while shifting continues.
// - An empty shift register takes the held character at once and starts shifting.
// - The shift register has no address; software cannot read or write it.
// - With nine-bit mode set, a ninth bit loaded beforehand is sent too.
// - As slave the port shifts using only the master's clock.
package srs_pkg;
    localparam int          DATA_W      = 32;
    localparam int          ADDR_W      = 32;
    localparam int          REG_W       = 8;
    localparam int          PRE_W       = 6;
    localparam int          CNT_W       = 4;
    // Register byte offsets.
    localparam logic [7:0]  OFF_RCS     = 8'h00;
    localparam logic [7:0]  OFF_DIV     = 8'h04;
    localparam logic [7:0]  OFF_TCS     = 8'h08;
    localparam logic [7:0]  OFF_THR     = 8'h0C;
    localparam logic [7:0]  OFF_STAT    = 8'h10;
    // receive_control_status fields.
    localparam int          RCS_SERIAL_PORT_ENABLE    = 7;
    localparam int          RCS_RX9     = 6;
    localparam int          RCS_SINGLE_RECEIVE_ENABLE    = 5;
    localparam int          RCS_CONTINUOUS_RECEIVE_ENABLE    = 4;
    // transmit_control_status fields.
    localparam int          TCS_CLOCK_SOURCE_SELECT    = 7;
    localparam int          TCS_TX9     = 6;
    localparam int          TCS_TRANSMIT_ENABLE    = 5;
    localparam int          TCS_SYNC    = 4;
    localparam int          TCS_HIGH_RATE_SELECT    = 2;
    localparam int          TCS_SHIFT_EMPTY_FLAG    = 1;
    localparam int          TCS_NINTH_TRANSMIT_BIT    = 0;
    // Status register fields.
    localparam int          ST_HOLD_EMP = 0;
    localparam int          ST_DATA_PIN = 1;
    localparam int          ST_CLK_PIN  = 2;
    // Prescaler limits: async low 64, async high 16, sync half bit 2.
    localparam logic [5:0]  PRE_ASYNC_LO = 6'h3F;
    localparam logic [5:0]  PRE_ASYNC_HI = 6'h0F;
    localparam logic [5:0]  PRE_SYNC     = 6'h01;
    localparam logic [3:0]  CHAR_BITS8   = 4'h8;
    localparam logic [3:0]  CHAR_BITS9   = 4'h9;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    typedef enum logic { SRS_IDLE, SRS_SHIFT } srs_state_t;
endpackage : srs_pkg

// *** srs_serial_port.sv ***
`timescale 1ns/10ps
module srs_serial_port (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [srs_pkg::ADDR_W-1:0]  haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [srs_pkg::DATA_W-1:0]  hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [srs_pkg::DATA_W-1:0]       hrdata,
    // Clock pin
    input  wire logic                        clockPinIn,
    output logic                             clockPinOut,
    output logic                             clockPinOe,
    // Data pin
    input  wire logic                        dataPinIn,
    output logic                             dataPinOut,
    output logic                             dataPinOe,
    // Status
    output logic                             txHoldEmpty,
    output logic                             shiftEmpty
);
    import srs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic                serialPortEnable_r;
    logic                rx9_r;
    logic                singleRxEnable_r;
    logic                contRxEnable_r;
    logic                clockSourceSelect_r;
    logic                nineBitTxEnable_r;
    logic                transmitEnable_r;
    logic                clockedMode_r;
    logic                highRateSelect_r;
    logic                ninthTxBit_r;
    logic [REG_W-1:0]    baudDivisor_r;
    logic [REG_W-1:0]    holdData_r;
    logic                holdFull_r;
    logic [PRE_W-1:0]    preCnt_r;
    logic [REG_W-1:0]    rateCnt_r;
    logic [REG_W:0]      txShift_r;
    logic [CNT_W-1:0]    bitsLeft_r;
    srs_state_t          state_r;
    logic                ckOut_r;
    logic                dtOut_r;
    logic                ckMeta_r;
    logic                ckSync_r;
    logic                ckPrev_r;
    logic                dtMeta_r;
    logic                dtSync_r;
    logic                wrPend_r;
    logic [7:0]          wrAddr_r;
    logic [DATA_W-1:0]   rdData_r;
    logic                addrPhase;
    logic                busWrite;
    logic [PRE_W-1:0]    preLimit;
    logic                rateTick;
    logic                masterMode;
    logic                slaveMode;
    logic                txMode;
    logic                leadEdge;
    logic                trailEdge;
    logic                loadShift;
    logic [REG_W-1:0]    tcsRead;
    logic [REG_W-1:0]    rcsRead;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdData_r;
    assign addrPhase = hsel && hready && (htrans == HTRANS_NSEQ);
    assign busWrite  = wrPend_r;

    // Capture the address phase of a write; data follows one cycle later.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            if (addrPhase) begin
                wrAddr_r <= haddr[7:0];
            end
        end
    end

    // Read views; the shift register itself is never mapped.
    assign rcsRead = {serialPortEnable_r, rx9_r, singleRxEnable_r, contRxEnable_r, 4'h0};
    assign tcsRead = {clockSourceSelect_r, nineBitTxEnable_r, transmitEnable_r,
                      clockedMode_r, 1'b0, highRateSelect_r, shiftEmpty, ninthTxBit_r};

    // Read data is registered in the address phase so it stands in the data phase.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_r <= '0;
        end else if (addrPhase && !hwrite) begin
            unique case (haddr[7:0])
                OFF_RCS:  rdData_r <= {24'h000000, rcsRead};
                OFF_DIV:  rdData_r <= {24'h000000, baudDivisor_r};
                OFF_TCS:  rdData_r <= {24'h000000, tcsRead};
                OFF_STAT: rdData_r <= {29'h0, ckSync_r, dtSync_r, txHoldEmpty};
                default:  rdData_r <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers written from the bus.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serialPortEnable_r  <= 1'b0;
            rx9_r               <= 1'b0;
            singleRxEnable_r    <= 1'b0;
            contRxEnable_r      <= 1'b0;
            clockSourceSelect_r <= 1'b0;
            nineBitTxEnable_r   <= 1'b0;
            transmitEnable_r    <= 1'b0;
            clockedMode_r       <= 1'b0;
            highRateSelect_r    <= 1'b0;
            ninthTxBit_r        <= 1'b0;
            baudDivisor_r       <= 8'h00;
        end else if (busWrite) begin
            if (wrAddr_r == OFF_RCS) begin
                serialPortEnable_r <= hwdata[RCS_SERIAL_PORT_ENABLE];
                rx9_r              <= hwdata[RCS_RX9];
                singleRxEnable_r   <= hwdata[RCS_SINGLE_RECEIVE_ENABLE];
                contRxEnable_r     <= hwdata[RCS_CONTINUOUS_RECEIVE_ENABLE];
            end
            if (wrAddr_r == OFF_TCS) begin
                clockSourceSelect_r <= hwdata[TCS_CLOCK_SOURCE_SELECT];
                nineBitTxEnable_r   <= hwdata[TCS_TX9];
                transmitEnable_r    <= hwdata[TCS_TRANSMIT_ENABLE];
                clockedMode_r       <= hwdata[TCS_SYNC];
                highRateSelect_r    <= hwdata[TCS_HIGH_RATE_SELECT];
                ninthTxBit_r        <= hwdata[TCS_NINTH_TRANSMIT_BIT];
            end
            if (wrAddr_r == OFF_DIV) begin
                baudDivisor_r <= hwdata[REG_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode. Setting either receive enable turns the data driver off,
    // so the pin is never driven while the port might be listening.
    assign masterMode = serialPortEnable_r && clockedMode_r && clockSourceSelect_r;
    assign slaveMode  = serialPortEnable_r && clockedMode_r && !clockSourceSelect_r;
    assign txMode     = serialPortEnable_r && clockedMode_r && transmitEnable_r
                        && !singleRxEnable_r && !contRxEnable_r;
    assign clockPinOe = masterMode;
    assign dataPinOe  = txMode;
    assign clockPinOut = ckOut_r;
    assign dataPinOut  = dtOut_r;

    ////////////////////////////////////////////////////////////////////////////
    // Rate timer. The prescaler sets the multiplier; synchronous mode counts
    // half bits so the clock pin gets an even duty cycle.
    always_comb begin
        if (clockedMode_r) begin
            preLimit = PRE_SYNC;
        end else if (highRateSelect_r) begin
            preLimit = PRE_ASYNC_HI;
        end else begin
            preLimit = PRE_ASYNC_LO;
        end
    end

    assign rateTick = (preCnt_r == preLimit) && (rateCnt_r == baudDivisor_r);

    // Free-running count; a divisor write restarts it so the new rate applies now.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preCnt_r  <= '0;
            rateCnt_r <= '0;
        end else if (busWrite && wrAddr_r == OFF_DIV) begin
            preCnt_r  <= '0;
            rateCnt_r <= '0;
        end else if (preCnt_r >= preLimit) begin
            preCnt_r  <= '0;
            rateCnt_r <= (rateCnt_r >= baudDivisor_r) ? '0 : rateCnt_r + 8'h01;
        end else begin
            preCnt_r  <= preCnt_r + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ckMeta_r <= 1'b0;
            ckSync_r <= 1'b0;
            ckPrev_r <= 1'b0;
            dtMeta_r <= 1'b0;
            dtSync_r <= 1'b0;
        end else begin
            ckMeta_r <= clockPinIn;
            ckSync_r <= ckMeta_r;
            ckPrev_r <= ckSync_r;
            dtMeta_r <= dataPinIn;
            dtSync_r <= dtMeta_r;
        end
    end

    // Leading edge is the rise of the clock, trailing edge its fall.
    always_comb begin
        if (masterMode) begin
            leadEdge  = (state_r == SRS_SHIFT) && rateTick && !ckOut_r;
            trailEdge = (state_r == SRS_SHIFT) && rateTick && ckOut_r;
        end else begin
            leadEdge  = slaveMode && (state_r == SRS_SHIFT) && ckSync_r && !ckPrev_r;
            trailEdge = slaveMode && (state_r == SRS_SHIFT) && !ckSync_r && ckPrev_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master clock: low when idle, one full cycle per bit while shifting.
    // Leaving transmit mode drops it at once, so an abort never adds a stray edge.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ckOut_r <= 1'b0;
        end else if (!masterMode || !txMode || state_r != SRS_SHIFT) begin
            ckOut_r <= 1'b0;
        end else if (rateTick) begin
            ckOut_r <= !ckOut_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Holding register. A new write wins over the transfer in the same cycle.
    assign loadShift   = (state_r == SRS_IDLE) && holdFull_r && txMode;
    assign txHoldEmpty = !holdFull_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            holdFull_r <= 1'b0;
            holdData_r <= 8'h00;
        end else if (busWrite && wrAddr_r == OFF_THR) begin
            holdFull_r <= 1'b1;
            holdData_r <= hwdata[REG_W-1:0];
        end else if (loadShift) begin
            holdFull_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shifter. Only data bits are sent, no framing, LSB first, ninth bit last.
    assign shiftEmpty = (state_r == SRS_IDLE);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r    <= SRS_IDLE;
            txShift_r  <= '0;
            bitsLeft_r <= '0;
        end else if (!txMode) begin
            state_r    <= SRS_IDLE;
            bitsLeft_r <= '0;
        end else begin
            unique case (state_r)
                SRS_IDLE: begin
                    if (loadShift) begin
                        state_r    <= SRS_SHIFT;
                        txShift_r  <= {ninthTxBit_r, holdData_r};
                        bitsLeft_r <= nineBitTxEnable_r ? CHAR_BITS9 : CHAR_BITS8;
                    end
                end
                SRS_SHIFT: begin
                    if (leadEdge && bitsLeft_r != '0) begin
                        txShift_r  <= {1'b0, txShift_r[REG_W:1]};
                        bitsLeft_r <= bitsLeft_r - 4'h1;
                    end else if (trailEdge && bitsLeft_r == '0) begin
                        state_r    <= SRS_IDLE;
                    end
                end
            endcase
        end
    end

    // Data pin changes only on a leading edge and holds until the next one.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dtOut_r <= 1'b0;
        end else if (leadEdge && bitsLeft_r != '0) begin
            dtOut_r <= txShift_r[0];
        end
    end

    // hsize is kept for the bus standard but not needed by word-only registers; rx9_r is only read back.
    logic unusedBits;
    assign unusedBits = ^{hsize, rx9_r};

endmodule : srs_serial_port

// *** srs_serial_port_chk.sv ***
`timescale 1ns/10ps
module srs_serial_port_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins and status
    input wire logic clockPinOut,
    input wire logic clockPinOe,
    input wire logic dataPinOut,
    input wire logic dataPinOe,
    input wire logic txHoldEmpty,
    input wire logic shiftEmpty
);
    // All checks share one clock; reset silences them.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // The slave never stalls and never reports an error.
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    // The master clock only rises while a character is being shifted.
    AST_CLK_ONLY_SHIFT: assert property ($rose(clockPinOut) |-> !shiftEmpty)
        else $error("clock edge with idle shifter");
    // An idle shifter leaves the clock low, so no extra cycles appear.
    AST_IDLE_LOW: assert property (shiftEmpty && $past(shiftEmpty) |-> !clockPinOut)
        else $error("clock high while idle");
    // Data may only move in the high half that follows the leading edge.
    AST_DATA_ON_LEAD: assert property (
        $changed(dataPinOut) && dataPinOe && clockPinOe && !shiftEmpty |-> clockPinOut)
        else $error("data changed away from leading edge");
    // Both drivers are on whenever the master clocks a bit out.
    AST_RISE_OE: assert property ($rose(clockPinOut) |-> clockPinOe && dataPinOe)
        else $error("clock edge without both drivers");
    // Half a bit is at least two clocks, the shortest synchronous rate.
    AST_HALF_MIN: assert property ($rose(clockPinOut) |-> clockPinOut [*2])
        else $error("clock high half too short");
    // A waiting character enters an idle shifter on the next cycle.
    AST_LOAD_AT_ONCE: assert property (
        !txHoldEmpty && shiftEmpty && dataPinOe |=> !shiftEmpty)
        else $error("held character not loaded");
    // Dropping transmit mode stops the shifter within two cycles.
    AST_ABORT_IDLE: assert property ($fell(dataPinOe) |-> ##[0:2] shiftEmpty)
        else $error("shifter kept running without transmit mode");

    // Main scenarios reached.
    COV_RISE: cover property ($rose(clockPinOut));
    COV_CHAIN: cover property ($rose(shiftEmpty) && !txHoldEmpty);
    COV_ABORT: cover property ($fell(dataPinOe) && !shiftEmpty);
endmodule : srs_serial_port_chk

bind srs_serial_port srs_serial_port_chk i_chk (
    .clk(clk), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp),
    .clockPinOut(clockPinOut), .clockPinOe(clockPinOe), .dataPinOut(dataPinOut),
    .dataPinOe(dataPinOe), .txHoldEmpty(txHoldEmpty), .shiftEmpty(shiftEmpty));

// *** srs_sync_slave.sv ***
`timescale 1ns/10ps
module srs_sync_slave (
    // Line levels
    input wire logic linkClk,
    input wire logic dataLine,
    // Clock this party drives when it is the master
    output logic     clkDrive
);
    bit      rxQ[$];
    realtime riseQ[$];

    // It only listens, so the shared data line is never driven here.
    initial clkDrive = 1'b0;

    // Bits are taken at the trailing edge, where they must be valid.
    always @(negedge linkClk) rxQ.push_back(dataLine);

    // Leading edge times let the bench measure the bit period.
    always @(posedge linkClk) riseQ.push_back($realtime);

    // Acting as master: pulses at a 200 ns period, out of phase with the core clock.
    task gen_clocks(input int n);
        #7;
        repeat (n) begin
            #100 clkDrive = 1'b1;
            #100 clkDrive = 1'b0;
        end
    endtask : gen_clocks
endmodule : srs_sync_slave

// *** test_serial_rate_and_sync_master.sv ***
`timescale 1ns/10ps
module test_serial_rate_and_sync_master;
    import srs_pkg::*;
    logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, floatPat, slaveClk;
    logic [31:0] haddr, hwdata, hrdata, rd, w;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        clockPinOut, clockPinOe, dataPinOut, dataPinOe, txHoldEmpty, shiftEmpty;
    logic [8:0]  c0, c1;
    logic [7:0]  dv;
    logic [7:0]  offs[5] = '{OFF_RCS, OFF_DIV, OFF_TCS, OFF_THR, 8'h14};
    logic [7:0]  rstv[5] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    wire         clockWire, dataWire;
    int          miscompares, n_tests;
    bit          expQ[$];

    // Released lines: clock rests low, data shows a toggling pattern.
    assign clockWire = clockPinOe ? clockPinOut : slaveClk;
    assign dataWire  = dataPinOe ? dataPinOut : floatPat;
    always #12.5 clk = ~clk;
    always @(posedge clk) floatPat <= ~floatPat;

    srs_serial_port i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .clockPinIn(clockWire),
        .clockPinOut(clockPinOut), .clockPinOe(clockPinOe), .dataPinIn(dataWire),
        .dataPinOut(dataPinOut), .dataPinOe(dataPinOe), .txHoldEmpty(txHoldEmpty),
        .shiftEmpty(shiftEmpty));
    srs_sync_slave i_slave (.linkClk(clockWire), .dataLine(dataWire), .clkDrive(slaveClk));

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, comparisons and bus cycles.
    task end_of_test;
        $display("Counts: %0d compares, %0d mismatches", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    // Received bits against the model queue; both queues are then emptied.
    task chk_stream(input string what);
        chk_word(i_slave.rxQ.size(), expQ.size(), what);
        foreach (expQ[i]) if (i < i_slave.rxQ.size()) chk_word(i_slave.rxQ[i], expQ[i], what);
        expQ.delete();
        i_slave.rxQ.delete();
        i_slave.riseQ.delete();
    endtask : chk_stream

    // One single transfer; the request stands until hready is seen high.
    task bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus

    task push_char(input logic [8:0] c, input int nb);
        for (int i = 0; i < nb; i++) expQ.push_back(c[i]);
    endtask : push_char

    task wait_idle;
        repeat (4000) begin
            @(posedge clk);
            if (shiftEmpty === 1'b1 && txHoldEmpty === 1'b1 && i_slave.rxQ.size() > 0) break;
        end
    endtask : wait_idle

    task wait_rises(input int n);
        repeat (3000) begin
            if (i_slave.riseQ.size() >= n) break;
            @(posedge clk);
        end
    endtask : wait_rises

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs well under a millisecond.
    initial begin
        #2000000;
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        clk = 1'b0; rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; floatPat = 1'b0; miscompares = 0; n_tests = 0;
        void'($urandom(42));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            bus(offs[i], 1'b0, 32'h0);
            chk_word(rd, {24'h0, rstv[i]}, "reset value");
        end
        bus(OFF_STAT, 1'b0, 32'h0);
        chk_word(rd & 32'h5, 32'h1, "holding empty");
        $display("test reset values done");
        w = $urandom;
        bus(OFF_DIV, 1'b1, w);
        bus(OFF_DIV, 1'b0, 32'h0);
        chk_word(rd, w & 32'hFF, "divisor");
        bus(OFF_TCS, 1'b1, ~w);
        bus(OFF_TCS, 1'b0, 32'h0);
        chk_word(rd, (~w & 32'hF5) | 32'h2, "transmit control");
        bus(8'h14, 1'b1, 32'hFFFFFFFF);
        bus(8'h14, 1'b0, 32'h0);
        chk_word(rd, 32'h0, "unmapped");
        $display("test register access done");
        // Master transmit: eight bits, high rate bit set, then nine bits.
        for (int k = 0; k < 3; k++) begin
            dv = (k == 0) ? 8'h00 : 8'($urandom_range(1, 3));
            c0 = 9'($urandom);
            c1 = 9'($urandom);
            bus(OFF_DIV, 1'b1, {24'h0, dv});
            bus(OFF_RCS, 1'b1, 32'h80);
            bus(OFF_TCS, 1'b1, {24'h0, 3'h5, 1'b1, 1'b0, k[0], 1'b0, c0[8]} | (k == 2 ? 32'h40 : 0));
            @(negedge clk);
            chk_word({clockPinOe, dataPinOe}, 2'h3, "drivers on");
            if (k == 2) c1[8] = c0[8];
            expQ.delete(); i_slave.rxQ.delete(); i_slave.riseQ.delete();
            bus(OFF_THR, 1'b1, {23'h0, c0});
            bus(OFF_THR, 1'b1, {23'h0, c1});
            @(negedge clk);
            chk_word({txHoldEmpty, shiftEmpty}, 2'h0, "second char waits");
            push_char(c0, k == 2 ? 9 : 8);
            push_char(c1, k == 2 ? 9 : 8);
            wait_idle();
            chk_word(int'(i_slave.riseQ[1] - i_slave.riseQ[0]), 100 * (dv + 1), "period");
            chk_stream("master bits");
            bus(OFF_STAT, 1'b0, 32'h0);
            chk_word(rd & 32'h6, {30'h0, (k == 2) ? c1[8] : c1[7], 1'b0}, "pin status");
        end
        $display("test master transmit done");
        // Rate change in mid-character, then abort by clearing transmit enable.
        bus(OFF_DIV, 1'b1, 32'hFF);
        bus(OFF_TCS, 1'b1, 32'hB0);
        bus(OFF_THR, 1'b1, $urandom & 32'hFF);
        wait_rises(1);
        bus(OFF_DIV, 1'b1, 32'h0);
        wait_rises(2);
        chk_word(32'(int'(i_slave.riseQ[1] - i_slave.riseQ[0]) < 400), 1, "rate restart");
        bus(OFF_DIV, 1'b1, 32'hFF);
        repeat (20) @(posedge clk);
        bus(OFF_TCS, 1'b1, 32'h90);
        repeat (3) @(negedge clk);
        chk_word({shiftEmpty, dataPinOe}, 2'h2, "abort");
        expQ.delete(); i_slave.rxQ.delete(); i_slave.riseQ.delete();
        $display("test rate restart and abort done");
        // Slave transmit on clocks from the far side.
        bus(OFF_TCS, 1'b1, 32'h30);
        @(negedge clk);
        chk_word({clockPinOe, dataPinOe}, 2'h1, "slave drivers");
        c0 = 9'($urandom);
        bus(OFF_THR, 1'b1, {23'h0, c0});
        repeat (4) @(posedge clk);
        i_slave.gen_clocks(8);
        repeat (10) @(posedge clk);
        push_char(c0, 8);
        chk_stream("slave bits");
        chk_word(shiftEmpty, 1, "slave idle");
        $display("test slave transmit done");
        end_of_test();
    end
endmodule : test_serial_rate_and_sync_master
